// >>> pkg/cas_pkg.sv
// ----------------------------------------------------------------------
// commutation alignment sequencer: shared constants and types
// ----------------------------------------------------------------------
package cas_pkg;

    // ------------------------------------------------------------------
    // register offsets on the parameter port
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_METHOD     = 16'h0386; // align_method_select
    localparam logic [15:0] ADDR_REPEAT     = 16'h0388; // align_repeat_count
    localparam logic [15:0] ADDR_STATUS     = 16'h038A; // align_status_code
    localparam logic [15:0] ADDR_HOLD       = 16'h038C; // vector_hold_time

    // reset values and legal ranges
    localparam logic [7:0]  METHOD_RST      = 8'h00;
    localparam logic [15:0] METHOD_MAX      = 16'h0001;
    localparam logic [7:0]  REPEAT_RST      = 8'h05;
    localparam logic [15:0] REPEAT_MAX      = 16'h0014;   // twenty loops
    localparam logic [15:0] HOLD_RST        = 16'h0002;   // 2 ms
    localparam logic [15:0] HOLD_MIN        = 16'h0001;
    localparam logic [15:0] HOLD_MAX        = 16'h00C8;   // 200 ms

    // delay limits (ms) and the defaults the outside should present
    localparam logic [7:0]  DLY_VEC_MAX     = 8'hC8;      // 200 ms
    localparam logic [7:0]  DLY_VEC_DEF     = 8'h05;
    localparam logic [7:0]  DLY_C2F_MAX     = 8'hC8;      // 200 ms
    localparam logic [7:0]  DLY_C2F_DEF     = 8'h32;
    localparam logic [15:0] DLY_LOOP_MAX    = 16'h07D0;   // 2000 ms
    localparam logic [15:0] DLY_LOOP_DEF    = 16'h0064;

    // method selector values
    localparam logic [7:0]  METHOD_SEARCH   = 8'h00;
    localparam logic [7:0]  METHOD_FIXED    = 8'h01;

    // status codes
    localparam logic [7:0]  ST_DONE         = 8'h00;
    localparam logic [7:0]  ST_PENDING      = 8'h01;
    localparam logic [7:0]  ST_RUNNING      = 8'h02;
    localparam logic [7:0]  ST_ERROR        = 8'h0A;
    localparam logic [7:0]  ST_NOT_NEEDED   = 8'h0B;

    // timing: one millisecond in clock cycles
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          MS_PERIOD_NS    = 1000000;
    localparam int          MS_CYCLES_DEF   = MS_PERIOD_NS / CLK_PERIOD_NS;

    // coarse scan: four vectors a quarter turn apart
    localparam logic [1:0]  LAST_VECTOR     = 2'h3;
    localparam int          VEC_SHIFT       = 14;

    // sequencer states
    typedef enum logic [3:0] {
        S_IDLE, S_CVEC, S_CGAP, S_C2F, S_FINE, S_LGAP, S_RD, S_ACC, S_DIV, S_ZERO
    } cas_state_t;

endpackage

// >>> hdl/cas_angle_mem.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// per-loop angle store, registered read
// ----------------------------------------------------------------------
module cas_angle_mem #(
    parameter int W     = 16,
    parameter int DEPTH = 20
) (
    // clock
    input  wire logic                       clk,
    // write side
    input  wire logic                       wr_en,
    input  wire logic [$clog2(DEPTH)-1:0]   wr_addr,
    input  wire logic [W-1:0]               wr_data,
    // read side
    input  wire logic [$clog2(DEPTH)-1:0]   rd_addr,
    output logic      [W-1:0]               rd_data
);
    logic [W-1:0] mem [DEPTH];  // one entry per search loop

    // write port and registered read
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // cas_angle_mem
`default_nettype wire

// >>> hdl/cas_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// commutation alignment sequencer
// ----------------------------------------------------------------------
// Overview of operation
// - 8-bit method selector, 0 search, 1 fixed
// - method 0: coarse current, fine velocity, repeated
// - average loop angles into commutation phase
// - method 1: poles zero, current mode, limit
// - method 1: zero minus rest angle becomes commutation angle
// - method 1 end restores poles and mode
// - repeat count 0..20, default five
// - apply vectors, record feedback per vector
// - read-only status: 0,2,10,11 codes
// - status 1 pending, starts at enable
// - reset status 1 or 11 by feedback
// - default status meaningful until first enable
// - vector hold 1..200 ms, default 2
// - inter-vector delay 0..200 ms
// - coarse-to-fine delay up to 200 ms
// - inter-loop delay up to 2000 ms, method 0
module cas_sequencer
    import cas_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF,  // clock cycles per millisecond
    parameter int MAX_LOOPS = 20,             // depth of the angle store
    parameter int ANGLE_W   = 16              // angle resolution, one turn
) (
    // clock and reset
    input  wire logic                CLK,
    input  wire logic                RST_B,
    // parameter port
    input  wire logic [15:0]         REG_ADDR,
    input  wire logic                REG_WR,
    input  wire logic [15:0]         REG_WR_DATA,
    output logic      [15:0]         REG_RD_DATA,
    // configuration held outside
    input  wire logic [15:0]         ALIGN_CURRENT_LIMIT,
    input  wire logic [7:0]          INTER_VECTOR_DELAY,
    input  wire logic [7:0]          COARSE_TO_FINE_DELAY,
    input  wire logic [15:0]         INTER_LOOP_DELAY,
    input  wire logic                FB_NEEDS_ALIGN,
    // drive and feedback
    input  wire logic                DRIVE_ENABLE,
    input  wire logic                MOVE_FAULT,
    input  wire logic [ANGLE_W-1:0]  POS_FEEDBACK,
    // power stage commands
    output logic                     VEC_ON,
    output logic      [ANGLE_W-1:0]  VEC_ANGLE,
    output logic      [15:0]         VEC_CURRENT,
    output logic                     MODE_OVERRIDE,
    output logic                     CURRENT_MODE,
    output logic                     POLE_ZERO,
    // result
    output logic      [ANGLE_W-1:0]  COMM_PHASE,
    output logic                     COMM_PHASE_LOAD
);
    localparam int AW    = $clog2(MAX_LOOPS);
    localparam int SUM_W = ANGLE_W + $clog2(MAX_LOOPS + 1);
    localparam int DW    = $clog2(MS_CYCLES + 1);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (MS_CYCLES < 1) begin : g_chk_ms
        $error("MS_CYCLES must be at least one");
    end
    if (MAX_LOOPS < 20 || ANGLE_W < 2 + VEC_SHIFT) begin : g_chk_size
        $error("store must hold twenty loops and angle needs two vector bits");
    end

    // ------------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------------
    cas_state_t         state_r, state_nxt;   // sequencer state
    logic [7:0]         method_r;             // align_method_select
    logic [7:0]         repeat_r;             // align_repeat_count
    logic [15:0]        hold_r;               // vector_hold_time
    logic [7:0]         status_r;             // align_status_code
    logic               en_d_r;               // enable delayed for edge
    logic               first_en_r;           // an enable has been seen
    logic [7:0]         loop_r;               // current search loop
    logic [7:0]         idx_r;                // averaging read index
    logic [1:0]         vec_r, vec_nxt;       // coarse vector index
    logic [15:0]        ms_left_r;            // remaining milliseconds
    logic [DW-1:0]      div_r;                // millisecond divider
    logic [ANGLE_W-1:0] coarse_r;             // coarse estimate
    logic [ANGLE_W-1:0] pos_c_r;              // feedback at coarse end
    logic [SUM_W-1:0]   sum_r;                // angle sum, then remainder
    logic [ANGLE_W-1:0] quot_r;               // mean being built
    logic               ld;                   // restart the timer
    logic [15:0]        ld_val;               // milliseconds to load
    logic [ANGLE_W-1:0] mem_rd;               // stored loop angle

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire ms_tick    = (div_r == DW'(MS_CYCLES - 1));
    wire tdone      = (ms_left_r == 16'h0000);
    wire running    = (state_r != S_IDLE);
    wire en_rise    = DRIVE_ENABLE & ~en_d_r;
    wire start      = ~running & en_rise & (status_r == ST_PENDING);
    wire abort      = running & (~DRIVE_ENABLE | MOVE_FAULT);
    wire wr_ok      = REG_WR & ~running;      // settings frozen while running
    wire wr_method  = wr_ok & (REG_ADDR == ADDR_METHOD) & (REG_WR_DATA <= METHOD_MAX);
    wire wr_repeat  = wr_ok & (REG_ADDR == ADDR_REPEAT) & (REG_WR_DATA <= REPEAT_MAX);
    wire wr_hold    = wr_ok & (REG_ADDR == ADDR_HOLD) & (REG_WR_DATA >= HOLD_MIN)
                      & (REG_WR_DATA <= HOLD_MAX);
    wire last_loop  = (loop_r == repeat_r - 8'h01);
    wire last_idx   = (idx_r == repeat_r - 8'h01);
    wire div_more   = (sum_r >= SUM_W'(repeat_r));
    wire fine_end   = (state_r == S_FINE) & tdone;
    wire cvec_end   = (state_r == S_CVEC) & tdone;
    // delays clamped to their legal ceilings
    wire [7:0]  dly_vec  = (INTER_VECTOR_DELAY > DLY_VEC_MAX) ? DLY_VEC_MAX
                                                               : INTER_VECTOR_DELAY;
    wire [7:0]  dly_c2f  = (COARSE_TO_FINE_DELAY > DLY_C2F_MAX) ? DLY_C2F_MAX
                                                                 : COARSE_TO_FINE_DELAY;
    wire [15:0] dly_loop = (INTER_LOOP_DELAY > DLY_LOOP_MAX) ? DLY_LOOP_MAX
                                                             : INTER_LOOP_DELAY;
    // fine angle corrects the coarse one by movement during the fine step
    wire [ANGLE_W-1:0] fine_angle = ANGLE_W'(coarse_r + pos_c_r - POS_FEEDBACK);
    wire [ANGLE_W-1:0] vec_angle  = ANGLE_W'({vec_nxt, {VEC_SHIFT{1'b0}}});
    wire [15:0] rd_mux = (REG_ADDR == ADDR_METHOD) ? {8'h00, method_r} :
                         (REG_ADDR == ADDR_REPEAT) ? {8'h00, repeat_r} :
                         (REG_ADDR == ADDR_STATUS) ? {8'h00, status_r} :
                         (REG_ADDR == ADDR_HOLD)   ? hold_r : 16'h0000;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        vec_nxt   = vec_r;
        ld        = 1'b0;
        ld_val    = hold_r;
        case (state_r)
            S_IDLE: begin
                if (start && method_r == METHOD_FIXED) begin
                    state_nxt = S_ZERO;
                    ld        = 1'b1;
                end else if (start && repeat_r != 8'h00) begin
                    state_nxt = S_CVEC;
                    vec_nxt   = 2'h0;
                    ld        = 1'b1;
                end
            end
            S_CVEC: if (tdone) begin
                state_nxt = S_CGAP;
                ld        = 1'b1;
                ld_val    = {8'h00, dly_vec};
            end
            S_CGAP: if (tdone) begin
                ld = 1'b1;
                if (vec_r == LAST_VECTOR) begin
                    state_nxt = S_C2F;
                    ld_val    = {8'h00, dly_c2f};
                end else begin
                    state_nxt = S_CVEC;
                    vec_nxt   = vec_r + 2'h1;
                end
            end
            S_C2F: if (tdone) begin
                state_nxt = S_FINE;
                ld        = 1'b1;
            end
            S_FINE: if (tdone) begin
                if (last_loop) begin
                    state_nxt = S_RD;
                end else begin
                    state_nxt = S_LGAP;
                    ld        = 1'b1;
                    ld_val    = dly_loop;
                end
            end
            S_LGAP: if (tdone) begin
                state_nxt = S_CVEC;
                vec_nxt   = 2'h0;
                ld        = 1'b1;
            end
            S_RD:    state_nxt = S_ACC;
            S_ACC:   state_nxt = last_idx ? S_DIV : S_RD;
            S_DIV:   if (!div_more) state_nxt = S_IDLE;
            S_ZERO:  if (tdone) state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
        // a dropped enable or a movement fault ends any run
        if (abort) begin
            state_nxt = S_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // millisecond timer; divider restarts on load so a delay is whole
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B || ld) begin
            div_r     <= '0;
            ms_left_r <= RST_B ? ld_val : 16'h0000;
        end else begin
            div_r <= ms_tick ? '0 : div_r + DW'(1);
            if (ms_tick && !tdone) begin
                ms_left_r <= ms_left_r - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // parameter registers, writes refused out of range
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            method_r <= METHOD_RST;
            repeat_r <= REPEAT_RST;
            hold_r   <= HOLD_RST;
        end else begin
            if (wr_method) method_r <= REG_WR_DATA[7:0];
            if (wr_repeat) repeat_r <= REG_WR_DATA[7:0];
            if (wr_hold)   hold_r   <= REG_WR_DATA;
        end
    end

    // ------------------------------------------------------------------
    // status code; reset takes the feedback strap synchronously
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            status_r   <= FB_NEEDS_ALIGN ? ST_PENDING : ST_NOT_NEEDED;
            first_en_r <= 1'b0;
            en_d_r     <= 1'b0;
        end else begin
            en_d_r <= DRIVE_ENABLE;
            if (en_rise) first_en_r <= 1'b1;
            if (abort) begin
                status_r <= ST_ERROR;
            end else if (start) begin
                // zero loops leaves nothing to average
                status_r <= (method_r == METHOD_SEARCH && repeat_r == 8'h00)
                            ? ST_ERROR : ST_RUNNING;
            end else if ((state_r == S_DIV && !div_more) || (state_r == S_ZERO && tdone)) begin
                status_r <= ST_DONE;
            end else if (!first_en_r && !running) begin
                // default tracks feedback type until the first enable
                status_r <= FB_NEEDS_ALIGN ? ST_PENDING : ST_NOT_NEEDED;
            end
        end
    end

    // ------------------------------------------------------------------
    // search datapath: vectors, loops, averaging
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state_r  <= S_IDLE;
            vec_r    <= 2'h0;
            loop_r   <= 8'h00;
            idx_r    <= 8'h00;
            coarse_r <= '0;
            pos_c_r  <= '0;
            sum_r    <= '0;
            quot_r   <= '0;
        end else begin
            state_r <= state_nxt;
            vec_r   <= vec_nxt;
            if (start) begin
                loop_r <= 8'h00;
                idx_r  <= 8'h00;
                sum_r  <= '0;
                quot_r <= '0;
            end
            if (cvec_end) begin
                // rotor sits on the vector: offset of last vector wins
                coarse_r <= ANGLE_W'(vec_angle - POS_FEEDBACK);
                pos_c_r  <= POS_FEEDBACK;
            end
            if (fine_end) loop_r <= loop_r + 8'h01;
            if (state_r == S_ACC) begin
                sum_r <= sum_r + SUM_W'(mem_rd);
                idx_r <= idx_r + 8'h01;
            end
            if (state_r == S_DIV && div_more) begin
                sum_r  <= sum_r - SUM_W'(repeat_r);
                quot_r <= quot_r + ANGLE_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs, registered; commands from the next state, result from the present state
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            VEC_ON          <= 1'b0;
            VEC_ANGLE       <= '0;
            VEC_CURRENT     <= 16'h0000;
            MODE_OVERRIDE   <= 1'b0;
            CURRENT_MODE    <= 1'b0;
            POLE_ZERO       <= 1'b0;
            COMM_PHASE      <= '0;
            COMM_PHASE_LOAD <= 1'b0;
            REG_RD_DATA     <= 16'h0000;
        end else begin
            VEC_ON        <= state_nxt inside {S_CVEC, S_FINE, S_ZERO};
            VEC_CURRENT   <= ALIGN_CURRENT_LIMIT;
            MODE_OVERRIDE <= (state_nxt != S_IDLE);
            CURRENT_MODE  <= state_nxt != S_FINE;
            POLE_ZERO     <= (state_nxt == S_ZERO);
            REG_RD_DATA   <= rd_mux;
            if (state_nxt == S_CVEC) VEC_ANGLE <= vec_angle;
            else if (state_nxt == S_FINE) VEC_ANGLE <= coarse_r;
            else VEC_ANGLE <= '0;
            COMM_PHASE_LOAD <= 1'b0;
            if (state_r == S_DIV && !div_more && !abort) begin
                COMM_PHASE      <= quot_r;
                COMM_PHASE_LOAD <= 1'b1;
            end else if (state_r == S_ZERO && tdone && !abort) begin
                COMM_PHASE      <= ANGLE_W'(-POS_FEEDBACK);
                COMM_PHASE_LOAD <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // loop angle store
    // ------------------------------------------------------------------
    cas_angle_mem #(
        .W      (ANGLE_W),
        .DEPTH  (MAX_LOOPS)
    ) u_mem (
        .clk     (CLK),
        .wr_en   (fine_end & ~abort),
        .wr_addr (loop_r[AW-1:0]),
        .wr_data (fine_angle),
        .rd_addr (idx_r[AW-1:0]),
        .rd_data (mem_rd)
    );
endmodule // cas_sequencer
`default_nettype wire

// >>> test/cas_motor_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// motor and feedback stand-in
// ----------------------------------------------------------------
module cas_motor_model (
    // clock
    input  wire logic        clk,
    // current on, and where the rotor comes to rest
    input  wire logic        vec_on,
    input  wire logic [15:0] rest,
    // feedback
    output logic      [15:0] pos
);
    // stiff rotor: the reading stands while no current flows
    initial pos = 16'h0000;
    // under current the rotor sits at its rest angle a cycle later
    always @(posedge clk) begin
        if (vec_on) pos <= rest;
    end
endmodule // cas_motor_model
`default_nettype wire

// >>> test/cas_sequencer_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// port checker for the sequencer
// ----------------------------------------------------------------
module cas_sequencer_chk
    import cas_pkg::*;
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST_B,
    // parameter port
    input wire logic [15:0] REG_ADDR,
    input wire logic [15:0] REG_RD_DATA,
    // inputs that cause things
    input wire logic [15:0] ALIGN_CURRENT_LIMIT,
    input wire logic        DRIVE_ENABLE,
    input wire logic        MOVE_FAULT,
    // commands and result
    input wire logic        VEC_ON,
    input wire logic [15:0] VEC_ANGLE,
    input wire logic [15:0] VEC_CURRENT,
    input wire logic        MODE_OVERRIDE,
    input wire logic        CURRENT_MODE,
    input wire logic        POLE_ZERO,
    input wire logic        COMM_PHASE_LOAD
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // a phase lands only at the end of a run
    a_load_after_run: assert property (COMM_PHASE_LOAD |-> $past(MODE_OVERRIDE))
        else $error("phase load outside a run");
    a_load_single: assert property (COMM_PHASE_LOAD |=> !COMM_PHASE_LOAD)
        else $error("phase load longer than one cycle");
    a_load_restores: assert property (COMM_PHASE_LOAD |-> !(MODE_OVERRIDE || POLE_ZERO))
        else $error("overrides still held at phase load");
    a_pole_current: assert property (POLE_ZERO |-> CURRENT_MODE && VEC_ANGLE == 16'h0000)
        else $error("zero-pole step not in current control");
    a_vec_limit: assert property (VEC_ON |-> VEC_CURRENT == ALIGN_CURRENT_LIMIT)
        else $error("vector current differs from limit");
    a_fine_velocity: assert property (VEC_ON && !CURRENT_MODE |-> MODE_OVERRIDE && !POLE_ZERO)
        else $error("velocity step outside search");
    a_vec_quarter: assert property (VEC_ON && CURRENT_MODE && !POLE_ZERO |->
        VEC_ANGLE[VEC_SHIFT-1:0] == '0)
        else $error("coarse vector off a quarter turn");
    // an abort releases the motor on the very next edge
    a_abort_enable: assert property ($fell(DRIVE_ENABLE) |=> !MODE_OVERRIDE && !COMM_PHASE_LOAD)
        else $error("run survived enable drop");
    a_fault_abort: assert property (MOVE_FAULT |=> !MODE_OVERRIDE)
        else $error("run survived a fault");
    a_status_codes: assert property ($past(REG_ADDR) == ADDR_STATUS |->
        REG_RD_DATA inside {16'h0000, 16'h0001, 16'h0002, 16'h000A, 16'h000B})
        else $error("illegal status code read");
endmodule // cas_sequencer_chk
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// self-checking bench for the sequencer
// ----------------------------------------------------------------
module tb
    import cas_pkg::*;
;
    logic        clk, rst_b, reg_wr, need, en, fault, rd_due, rd_tick;
    logic        vec_on, ovr, cmode, pole0, load;
    logic [15:0] addr, wdat, rdat, lim, ldly, fb, rest, vang, vcur, phase;
    logic [7:0]  vdly, cdly;
    logic [15:0] rd_q[$], ph_q[$];
    logic [15:0] adr[4] = '{ADDR_METHOD, ADDR_REPEAT, ADDR_HOLD, ADDR_STATUS};
    logic [15:0] dft[4] = '{16'h0000, 16'h0005, 16'h0002, 16'h0001};
    logic [15:0] ill[4] = '{16'h0002, 16'h0015, 16'h00C9, 16'h0000};
    int          bad_count, check_count, seed, n;

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    cas_sequencer #(.MS_CYCLES(4)) u_cas_sequencer (
        .CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WR(reg_wr), .REG_WR_DATA(wdat),
        .REG_RD_DATA(rdat), .ALIGN_CURRENT_LIMIT(lim), .INTER_VECTOR_DELAY(vdly),
        .COARSE_TO_FINE_DELAY(cdly), .INTER_LOOP_DELAY(ldly), .FB_NEEDS_ALIGN(need),
        .DRIVE_ENABLE(en), .MOVE_FAULT(fault), .POS_FEEDBACK(fb), .VEC_ON(vec_on),
        .VEC_ANGLE(vang), .VEC_CURRENT(vcur), .MODE_OVERRIDE(ovr), .CURRENT_MODE(cmode),
        .POLE_ZERO(pole0), .COMM_PHASE(phase), .COMM_PHASE_LOAD(load));
    cas_motor_model u_cas_motor_model (.clk(clk), .vec_on(vec_on), .rest(rest), .pos(fb));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // phase loads: a load with no note pending is a mismatch
    task automatic cmp_phase(input logic [15:0] got);
        if (ph_q.size() == 0) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, 16'h0000);
        end else begin
            cmp(got, ph_q.pop_front());
        end
    endtask
    task automatic wrap_up();
        // notes never answered count as mismatches
        bad_count += rd_q.size() + ph_q.size();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // reset held two cycles; feedback type sampled meanwhile
    task automatic rst(input logic nd);
        @(negedge clk);
        rst_b = 1'b0;
        en = 1'b0;
        need = nd;
        lim = 16'($random(seed));
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdat = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // read data shows one cycle after the address
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(negedge clk);
        addr = a;
        rd_due = 1'b1;
        rd_q.push_back(e);
        @(negedge clk);
        rd_due = 1'b0;
    endtask
    // enable, optionally abort (1 fault, 2 enable drop), wait for release
    task automatic run(input int ab);
        int k;
        @(negedge clk);
        en = 1'b1;
        repeat (3) @(negedge clk);
        if (ab != 0) rd(ADDR_STATUS, {8'h00, ST_RUNNING});
        fault = (ab == 1);
        if (ab == 2) en = 1'b0;
        for (k = 0; k < 20000 && ovr !== 1'b0; k++) @(negedge clk);
        fault = 1'b0;
        if (k == 20000) begin
            bad_count++;
            wrap_up();
        end
    endtask

    // ------------------------------------------------------------
    // result watcher: oldest note against what appears
    // ------------------------------------------------------------
    always @(posedge clk) begin
        rd_tick <= rd_due;
        if (rd_tick) cmp(rdat, rd_q.pop_front());
        if (load === 1'b1) cmp_phase(phase);
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 38746;
        {bad_count, check_count} = '0;
        {rst_b, reg_wr, need, en, fault, rd_due} = '0;
        {addr, wdat, lim, rest} = '0;
        {vdly, cdly, ldly} = '0;
        rst(1'b1);
        // defaults, then refused writes leave them alone
        for (int i = 0; i < 4; i++) rd(adr[i], dft[i]);
        rd(16'h0390, 16'h0000);
        for (int i = 0; i < 4; i++) wr(adr[i], ill[i]);
        wr(ADDR_HOLD, 16'h0000);
        for (int i = 0; i < 4; i++) rd(adr[i], dft[i]);
        wr(ADDR_REPEAT, 16'h0014);
        rd(ADDR_REPEAT, 16'h0014);
        n = 1 + ($random(seed) & 32'hFFFF) % 20;
        wr(ADDR_REPEAT, 16'(n));
        rd(ADDR_REPEAT, 16'(n));
        wr(ADDR_HOLD, 16'h0001);
        // search method: every loop finds the same angle, so the mean is exact
        vdly = 8'($random(seed) & 3);
        cdly = 8'($random(seed) & 3);
        ldly = 16'($random(seed) & 3);
        rest = 16'hC000 - 16'($random(seed) & 16'h00FF);
        ph_q.push_back(16'hC000 - rest);
        run(0);
        rd(ADDR_STATUS, {8'h00, ST_DONE});
        en = 1'b0;
        run(0);
        rd(ADDR_STATUS, {8'h00, ST_DONE});
        // fixed vector: zero minus the rest angle becomes the phase
        rst(1'b1);
        wr(ADDR_METHOD, 16'h0001);
        rest = 16'($random(seed));
        ph_q.push_back(16'h0000 - rest);
        run(0);
        rd(ADDR_STATUS, {8'h00, ST_DONE});
        // fault and enable drop both end in error
        for (int k = 1; k < 3; k++) begin
            rst(1'b1);
            wr(ADDR_METHOD, 16'h0001);
            run(k);
            rd(ADDR_STATUS, {8'h00, ST_ERROR});
        end
        rst(1'b1);
        wr(ADDR_REPEAT, 16'h0000);
        run(0);
        rd(ADDR_STATUS, {8'h00, ST_ERROR});
        // feedback type without need: status stays put after enable
        rst(1'b0);
        rd(ADDR_STATUS, {8'h00, ST_NOT_NEEDED});
        run(0);
        need = 1'b1;
        rd(ADDR_STATUS, {8'h00, ST_NOT_NEEDED});
        // let the last read be compared before closing
        repeat (2) @(negedge clk);
        wrap_up();
    end
endmodule // tb

bind cas_sequencer cas_sequencer_chk u_cas_sequencer_chk (
    .CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_RD_DATA(REG_RD_DATA),
    .ALIGN_CURRENT_LIMIT(ALIGN_CURRENT_LIMIT), .DRIVE_ENABLE(DRIVE_ENABLE),
    .MOVE_FAULT(MOVE_FAULT), .VEC_ON(VEC_ON), .VEC_ANGLE(VEC_ANGLE),
    .VEC_CURRENT(VEC_CURRENT), .MODE_OVERRIDE(MODE_OVERRIDE), .CURRENT_MODE(CURRENT_MODE),
    .POLE_ZERO(POLE_ZERO), .COMM_PHASE_LOAD(COMM_PHASE_LOAD));
`default_nettype wire
